/* lisc_ctrl.sv */
`include "lisc_consts.svh"

module lisc_ctrl
  import lisc_pkg::*;
(
  input  wire logic          clk,                // 250 MHz system clock
  input  wire logic          reset_n,            // Hard reset, async, active low
  input  wire logic          soft_reset,         // Soft reset pulse, same clock
  input  wire lisc_bus_req_t req,                // Register access, offset within module
  output lisc_bus_rsp_t      rsp,                // Read data and valid
  input  wire lisc_iack_t    iack,               // Interrupt acknowledge cycle
  input  wire logic          acfail_n,           // Backplane power-fail line pin
  input  wire logic          sysfail_n,          // Backplane system-fail line pin
  input  wire logic [7:1]    irq_n,              // Backplane IRQ line pins
  input  wire logic          backoff_event,      // Deadlock detected pulse
  input  wire logic          backoff_clear_bit,  // Link control backoff clear write
  input  wire logic          async_trig_status_n,// Async trigger status, low = fired
  input  wire logic          sync_trig_status_n, // Sync trigger status, low = fired
  input  wire logic          async_trig_ack_reg, // Async trigger ack register read
  input  wire logic          sync_trig_ack_reg,  // Sync trigger ack register read
  output logic      [7:1]    irq_drive           // High pulls the IRQ line low
);

  lisc_state_t st;
  lisc_state_t next_st;

  logic [8:0] pins_sync;
  logic [3:0] rise;
  logic       acfail_live;
  logic       sysfail_live;
  logic [7:1] irq_live;
  logic       hit;
  logic       wr;
  logic       rd;
  logic       lvl_on;
  logic       ack_here;
  logic       trig_event;
  logic       local_req;
  logic [15:0] rd_word;

  lisc_sync #(.W(9)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({~acfail_n, ~sysfail_n, ~irq_n}),
    .q       (pins_sync)
  );

  assign acfail_live  = pins_sync[8];
  assign sysfail_live = pins_sync[7];
  assign irq_live     = pins_sync[6:0];

  lisc_edge #(.W(4)) u_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .lvl     ({acfail_live, sysfail_live, ~async_trig_status_n, ~sync_trig_status_n}),
    .rise    (rise)
  );

  assign hit        = (req.addr == `LISC_ISC_OFFSET);                 // RULE_18
  assign wr         = req.wr && hit;
  assign rd         = req.rd && hit;
  assign lvl_on     = (st.lvl_sel != 3'h0);                          // RULE_03
  assign ack_here   = iack.valid && lvl_on && (iack.level == st.lvl_sel);
  assign trig_event = rise[1] | rise[0];                               // RULE_12

  always_comb begin
    rd_word = 16'h0000;
    rd_word[`LISC_LVL_HI:`LISC_LVL_LO] = st.lvl_sel;
    rd_word[`LISC_PF_PEND_BIT]         = st.pf_pend;                   // RULE_05
    rd_word[`LISC_BACKOFF_BIT]         = st.backoff_flag;              // RULE_08
    rd_word[`LISC_TRIG_BIT]            = st.trig_pend;
    rd_word[`LISC_SYSFAIL_BIT]         = sysfail_live;                 // RULE_15
    rd_word[`LISC_ACFAIL_BIT]          = acfail_live;                  // RULE_19
    rd_word[`LISC_SF_PEND_BIT]         = st.sf_pend;                   // RULE_20
    rd_word[`LISC_IRQ_HI:`LISC_IRQ_LO] = irq_live;                     // RULE_21
  end

  always_comb begin
    next_st = st;
    // Register writes; reserved bits 12 and 7 are ignored
    if (wr) begin
      next_st.lvl_sel = req.wdata[`LISC_LVL_HI:`LISC_LVL_LO];          // RULE_03
      next_st.irq_en  = req.wdata[`LISC_EN_HI:`LISC_EN_LO];            // RULE_07
    end
    // Acknowledge withdraws the local requests of the selected level
    if (ack_here) begin
      next_st.pf_pend  = 1'b0;                                         // RULE_06
      next_st.sf_pend  = 1'b0;                                         // RULE_20
      next_st.bk_req   = 1'b0;                                         // RULE_10
      next_st.trig_req = 1'b0;                                         // RULE_10
    end
    // New events win over an acknowledge or clear bit in the same cycle, not over soft reset
    if (rise[3] && st.irq_en[0] && lvl_on) begin
      next_st.pf_pend = 1'b1;                                          // RULE_19
    end
    if (rise[2] && st.irq_en[1] && lvl_on) begin
      next_st.sf_pend = 1'b1;                                          // RULE_16
    end
    if (backoff_event && st.irq_en[3] && lvl_on) begin
      next_st.bk_req = 1'b1;                                           // RULE_11
    end
    if (trig_event && st.irq_en[2] && lvl_on) begin
      next_st.trig_req = 1'b1;                                         // RULE_14
    end
    if (backoff_clear_bit) begin
      next_st.backoff_flag = 1'b0;                                     // RULE_09
    end
    if (backoff_event) begin
      next_st.backoff_flag = 1'b1;                                     // RULE_08
    end
    if (async_trig_ack_reg || sync_trig_ack_reg) begin
      next_st.trig_pend = 1'b0;                                        // RULE_13
    end
    if (trig_event) begin
      next_st.trig_pend = 1'b1;                                        // RULE_12
    end
    // Drive bits drop when their line is acknowledged; a write then sets them
    if (iack.valid) begin
      next_st.drive = st.drive & ~lisc_onehot(iack.level);             // RULE_21
    end
    if (wr) begin
      next_st.drive = req.wdata[`LISC_IRQ_HI:`LISC_IRQ_LO];            // RULE_17
    end
    // Soft reset clears the lower byte only
    if (soft_reset) begin
      next_st.sf_pend = 1'b0;                                          // RULE_02
      next_st.drive   = 7'h00;                                         // RULE_02
    end
    local_req = (next_st.pf_pend | next_st.sf_pend |
                 next_st.bk_req | next_st.trig_req);                   // RULE_04
    next_st.irq_drive = next_st.drive |
                        (local_req ? lisc_onehot(next_st.lvl_sel) : 7'h00); // RULE_22
    next_st.rsp.valid = rd;
    next_st.rsp.data  = rd ? rd_word : 16'h0000;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;                                                        // RULE_01
    end else begin
      st <= next_st;
    end
  end

  assign rsp       = st.rsp;
  assign irq_drive = st.irq_drive;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_soft_lower_clear: assert property ( // RULE_02
    soft_reset |=> st.drive == 7'h00 && !st.sf_pend)
    else $error("soft reset left lower byte set");

  a_soft_keep_upper: assert property ( // RULE_01
    soft_reset && !wr |=> st.lvl_sel == $past(st.lvl_sel) && st.irq_en == $past(st.irq_en))
    else $error("soft reset changed upper byte");

  a_ack_clears_pf: assert property ( // RULE_06
    ack_here && !rise[3] |=> !st.pf_pend)
    else $error("power-fail pending survived acknowledge");

  a_pf_sets_line: assert property ( // RULE_05
    rise[3] && st.irq_en[0] && lvl_on && !wr |=>
    st.pf_pend ##0 (irq_drive & lisc_onehot(st.lvl_sel)) != 7'h00)
    else $error("power-fail did not raise the selected line");

  a_backoff_sticky: assert property ( // RULE_09
    st.backoff_flag && !backoff_clear_bit |=> st.backoff_flag)
    else $error("backoff flag dropped without clear");

  a_bk_sets_flag: assert property ( // RULE_08
    backoff_event |=> st.backoff_flag)
    else $error("backoff flag not set by deadlock");

  a_bk_raises_irq: assert property ( // RULE_11
    backoff_event && st.irq_en[3] && lvl_on && !wr |=>
    (irq_drive & lisc_onehot(st.lvl_sel)) != 7'h00)
    else $error("backoff did not raise interrupt");

  a_ack_drops_req: assert property ( // RULE_10
    ack_here && !backoff_event && !trig_event |=> !st.bk_req && !st.trig_req)
    else $error("backoff or trigger request survived acknowledge");

  a_trig_sets_pend: assert property ( // RULE_12
    trig_event |=> st.trig_pend)
    else $error("trigger bit not set by trigger edge");

  a_trig_ack_clear: assert property ( // RULE_13
    (async_trig_ack_reg || sync_trig_ack_reg) && !trig_event |=> !st.trig_pend)
    else $error("trigger bit not cleared by ack read");

  a_trig_raises_irq: assert property ( // RULE_14
    trig_event && st.irq_en[2] && lvl_on && !wr |=>
    (irq_drive & lisc_onehot(st.lvl_sel)) != 7'h00)
    else $error("trigger did not raise interrupt");

  a_sf_raises_irq: assert property ( // RULE_16
    rise[2] && st.irq_en[1] && lvl_on && !wr && !soft_reset |=>
    st.sf_pend ##0 (irq_drive & lisc_onehot(st.lvl_sel)) != 7'h00)
    else $error("system fail did not raise interrupt");

  a_ack_clears_sf: assert property ( // RULE_20
    ack_here && !rise[2] |=> !st.sf_pend)
    else $error("system-fail pending survived acknowledge");

  a_lvl_zero_quiet: assert property ( // RULE_03
    st.lvl_sel == 3'h0 |-> irq_drive == st.drive)
    else $error("local request driven while disabled");

  a_local_drives: assert property ( // RULE_04
    (st.pf_pend || st.sf_pend || st.bk_req || st.trig_req) && lvl_on |->
    (irq_drive & lisc_onehot(st.lvl_sel)) != 7'h00)
    else $error("pending local source not driven");

  a_local_idle: assert property ( // RULE_22
    !(st.pf_pend || st.sf_pend || st.bk_req || st.trig_req) |-> irq_drive == st.drive)
    else $error("local line driven with no source");

  a_write_sets_drive: assert property ( // RULE_17
    wr && !soft_reset |=> st.drive == $past(req.wdata[6:0]))
    else $error("drive bits not taken from write");

  a_iack_drops_drive: assert property ( // RULE_21
    iack.valid && !wr && !soft_reset |=> (st.drive & lisc_onehot($past(iack.level))) == 7'h00)
    else $error("drive bit survived its acknowledge");

  a_miss_no_answer: assert property ( // RULE_18
    req.rd && !hit |=> !rsp.valid)
    else $error("answer to an unmapped read");

  a_read_answer: assert property ( // RULE_15
    rd |=> rsp.valid && rsp.data[9] == $past(sysfail_live))
    else $error("read answer wrong");

  a_acfail_read: assert property ( // RULE_19
    rd |=> rsp.data[8] == $past(acfail_live))
    else $error("power-fail line not shown in read");

  c_pf_ack: cover property (st.pf_pend ##1 ack_here);
  c_drive_write: cover property (wr && req.wdata[6:0] != 7'h00);
  c_trig_set: cover property (trig_event && st.irq_en[2]);
  c_sf_ack: cover property (st.sf_pend ##1 ack_here);
  c_soft_keep: cover property (soft_reset && st.lvl_sel != 3'h0);

endmodule : lisc_ctrl

/* lisc_consts.svh */
// Notes on behaviour
// RULE_01: A hard reset clears bits 15-8; a soft reset leaves them unchanged.
// RULE_02: Hard and soft reset both clear bits 7-0.
// RULE_03: Selector bits 15-13 pick IRQ line 1-7; zero disables local interrupts.
// RULE_04: Four local sources share the level: backoff, trigger, power fail, system fail.
// RULE_05: Read bit 12 shows a power-fail interrupt driven on the selected level.
// RULE_06: Power-fail pending clears on an acknowledge cycle for the selected level.
// RULE_07: Software writes zero into reserved write bits 12 and 7.
// RULE_08: Read bit 11 sets when a backplane transfer hits an inbound link deadlock.
// RULE_09: The backoff flag holds until the link control backoff clear bit is written.
// RULE_10: Backoff and trigger requests drop on an acknowledge for the selected level.
// RULE_11: With write bit 11 set, a backoff raises an interrupt on the level.
// RULE_12: Read bit 10 sets when either trigger status bit is cleared by an edge.
// RULE_13: The trigger bit clears when software reads the trigger acknowledge registers.
// RULE_14: With write bit 10 set, a trigger interrupt raises an interrupt on the level.
// RULE_15: Read bit 9 returns the live system-fail line level, unlatched.
// RULE_16: With write bit 9 set, system-fail assertion raises an interrupt on the level.
// RULE_17: Lower byte drives each IRQ line by write and reports each line by read.
// RULE_18: The register sits at base plus 2A for 16-bit read and write.
// RULE_19: Write bit 8 enables power-fail interrupts; read bit 8 shows the live line.
// RULE_20: Read bit 7 shows a system-fail interrupt; it clears on the level's acknowledge.
// RULE_21: Drive bits assert lines, self-clear on their acknowledge; read bits mirror IRQ7-1.
// RULE_22: Local request is the OR of enabled sources, driven only for a nonzero level.
`ifndef LISC_CONSTS_SVH
`define LISC_CONSTS_SVH

`define LISC_ISC_OFFSET   8'h2a
`define LISC_LVL_HI       15
`define LISC_LVL_LO       13
`define LISC_PF_PEND_BIT  12
`define LISC_BACKOFF_BIT  11
`define LISC_TRIG_BIT     10
`define LISC_SYSFAIL_BIT  9
`define LISC_ACFAIL_BIT   8
`define LISC_SF_PEND_BIT  7
`define LISC_EN_HI        11
`define LISC_EN_LO        8
`define LISC_IRQ_HI       6
`define LISC_IRQ_LO       0
`define LISC_UPPER_RST    8'h00
`define LISC_LOWER_RST    8'h00
`define LISC_SYNC_STAGES  2

`endif

/* lisc_pkg.sv */
package lisc_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } lisc_bus_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        valid;
  } lisc_bus_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } lisc_iack_t;

  // irq_en order: [3] backoff, [2] trigger, [1] system fail, [0] power fail
  typedef struct packed {
    logic [2:0]    lvl_sel;
    logic [3:0]    irq_en;
    logic          pf_pend;
    logic          backoff_flag;
    logic          trig_pend;
    logic          bk_req;
    logic          trig_req;
    logic          sf_pend;
    logic [6:0]    drive;
    logic [7:1]    irq_drive;
    lisc_bus_rsp_t rsp;
  } lisc_state_t;

  function automatic logic [7:1] lisc_onehot(input logic [2:0] lvl);
    logic [7:0] t;
    t = 8'h01 << lvl;
    return t[7:1];
  endfunction : lisc_onehot

endpackage : lisc_pkg

/* lisc_sync.sv */
module lisc_sync #(
  parameter int W = 9
) (
  input  wire logic         clk,      // System clock
  input  wire logic         reset_n,  // Async reset, active low
  input  wire logic [W-1:0] d,        // Asynchronous levels
  output logic      [W-1:0] q         // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lisc_sync_st_t;

  lisc_sync_st_t st;
  lisc_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : lisc_sync

/* lisc_edge.sv */
module lisc_edge #(
  parameter int W = 4
) (
  input  wire logic         clk,      // System clock
  input  wire logic         reset_n,  // Async reset, active low
  input  wire logic [W-1:0] lvl,      // Active-high levels, same clock
  output logic      [W-1:0] rise      // One-cycle pulse on each rising edge
);
  typedef struct packed {
    logic [W-1:0] prev;
  } lisc_edge_st_t;

  lisc_edge_st_t st;
  lisc_edge_st_t next_st;

  always_comb begin
    next_st      = st;
    next_st.prev = lvl;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = lvl & ~st.prev;
endmodule : lisc_edge

/* lisc_vme_model.sv */
module lisc_vme_model
  import lisc_pkg::*;
(
  input  wire logic [7:1] irq_drive,  // Lines pulled low by the block
  input  wire logic [7:1] other_irq,  // Lines pulled low by other boards
  input  wire logic       clk,        // System clock
  output logic      [7:1] irq_n,      // Backplane IRQ lines
  output lisc_iack_t      iack        // Acknowledge cycles from the handler
);
  timeunit 1ns;
  timeprecision 1ps;

  // Open-drain lines with pull-ups: any driver wins low
  assign irq_n = ~(irq_drive | other_irq);

  initial iack = '0;

  task automatic ack(input logic [2:0] lvl);
    iack = '{valid: 1'b1, level: lvl};
    @(posedge clk);
    #1;
    iack = '0;
  endtask : ack
endmodule : lisc_vme_model

/* lisc_ctrl_test.sv */
module lisc_ctrl_test
  import lisc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clk = 0, reset_n = 0, soft_reset = 0, acfail_n = 1, sysfail_n = 1;
  logic          bk_ev = 0, bk_clr = 0, as_n = 1, ss_n = 1, as_ack = 0, ss_ack = 0;
  logic [7:1]    other_irq = '0, irq_n, irq_drive;
  lisc_bus_req_t req = '0;
  lisc_bus_rsp_t rsp;
  lisc_iack_t    iack;
  int            miscompares = 0, n_compared = 0;

  always #2 clk = ~clk;

  lisc_ctrl uut (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset), .req(req), .rsp(rsp),
    .iack(iack), .acfail_n(acfail_n), .sysfail_n(sysfail_n), .irq_n(irq_n),
    .backoff_event(bk_ev), .backoff_clear_bit(bk_clr), .async_trig_status_n(as_n),
    .sync_trig_status_n(ss_n), .async_trig_ack_reg(as_ack), .sync_trig_ack_reg(ss_ack),
    .irq_drive(irq_drive));

  lisc_vme_model vme (.irq_drive(irq_drive), .other_irq(other_irq), .clk(clk), .irq_n(irq_n),
    .iack(iack));

  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : cyc

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_word

  task automatic chk_irq(input logic [7:1] got, input logic [7:1] exp, input string msg);
    chk_word({9'h000, got}, {9'h000, exp}, msg);
  endtask : chk_irq

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc();
    s = 1'b0;
    cyc();
  endtask : pulse

  task automatic wr(input logic [15:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: 8'h2a, wdata: d};
    cyc();
    req = '0;
    cyc();
  endtask : wr

  // Waits for the IRQ lines to settle through the input synchronisers first
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string msg);
    cyc(3);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    cyc();
    req = '0;
    chk_word({15'h0000, rsp.valid}, {15'h0000, a == 8'h2a}, "read answer");
    if (a == 8'h2a) chk_word(rsp.data, exp, msg);
    cyc();
  endtask : rd_chk

  task automatic wait_irq(input logic [7:1] exp, input string msg);
    int i;
    for (i = 0; i < 8 && irq_drive !== exp; i++) cyc();
    chk_irq(irq_drive, exp, msg);
    if (irq_drive !== exp) end_of_test();
  endtask : wait_irq

  task automatic t_reset();
    rd_chk(8'h2a, 16'h0000, "hard reset value");
    rd_chk(8'h2c, 16'h0000, "unmapped read");
    req = '{rd: 1'b0, wr: 1'b1, addr: 8'h2c, wdata: 16'he07f};
    cyc();
    req = '0;
    rd_chk(8'h2a, 16'h0000, "unmapped write ignored");
    $display("test reset done");
  endtask : t_reset

  task automatic t_backoff();
    for (int i = 1; i < 8; i++) begin
      wr({3'(i), 13'h0800});
      pulse(bk_ev);
      wait_irq(7'(1 << (i - 1)), "backoff level");
      rd_chk(8'h2a, {3'(i), 6'b010000, 7'(1 << (i - 1))}, "backoff set");
      vme.ack(3'(i));
      wait_irq(7'h00, "backoff ack");
      rd_chk(8'h2a, {3'(i), 13'h0800}, "backoff held");
      pulse(bk_clr);
      rd_chk(8'h2a, {3'(i), 13'h0000}, "backoff cleared");
    end
    wr(16'h0f00);
    pulse(bk_ev);
    wait_irq(7'h00, "level zero");
    rd_chk(8'h2a, 16'h0800, "level zero flag");
    pulse(bk_clr);
    $display("test backoff done");
  endtask : t_backoff

  task automatic t_trigger();
    for (int k = 0; k < 2; k++) begin
      wr(16'h4400);
      if (k == 0) as_n = 1'b0;
      else ss_n = 1'b0;
      wait_irq(7'h02, "trigger irq");
      rd_chk(8'h2a, 16'h4402, "trigger set");
      vme.ack(3'h2);
      wait_irq(7'h00, "trigger ack");
      rd_chk(8'h2a, 16'h4400, "trigger held");
      if (k == 0) pulse(as_ack);
      else pulse(ss_ack);
      rd_chk(8'h2a, 16'h4000, "trigger cleared");
      as_n = 1'b1;
      ss_n = 1'b1;
    end
    $display("test trigger done");
  endtask : t_trigger

  task automatic t_fail();
    wr(16'ha200);
    sysfail_n = 1'b0;
    wait_irq(7'h10, "system fail irq");
    rd_chk(8'h2a, 16'ha290, "system fail set");
    vme.ack(3'h5);
    wait_irq(7'h00, "system fail ack");
    rd_chk(8'h2a, 16'ha200, "system fail live");
    sysfail_n = 1'b1;
    rd_chk(8'h2a, 16'ha000, "system fail released");
    wr(16'he100);
    acfail_n = 1'b0;
    wait_irq(7'h40, "power fail irq");
    rd_chk(8'h2a, 16'hf140, "power fail set");
    vme.ack(3'h7);
    wait_irq(7'h00, "power fail ack");
    rd_chk(8'h2a, 16'he100, "power fail cleared");
    acfail_n = 1'b1;
    $display("test fail lines done");
  endtask : t_fail

  task automatic t_drive();
    wr(16'h207f);
    wait_irq(7'h7f, "drive all");
    vme.ack(3'h5);
    wait_irq(7'h6f, "drive self clear");
    rd_chk(8'h2a, 16'h206f, "line mirror");
    other_irq = 7'h10;
    rd_chk(8'h2a, 16'h207f, "foreign line");
    other_irq = 7'h00;
    pulse(soft_reset);
    chk_irq(irq_drive, 7'h00, "soft reset drive");
    rd_chk(8'h2a, 16'h2000, "soft reset keeps level");
    reset_n = 1'b0;
    cyc();
    reset_n = 1'b1;
    rd_chk(8'h2a, 16'h0000, "hard reset mid run");
    $display("test drive done");
  endtask : t_drive

  initial begin
    cyc(4);
    reset_n = 1'b1;
    t_reset();
    t_backoff();
    t_trigger();
    t_fail();
    t_drive();
    end_of_test();
  end
endmodule : lisc_ctrl_test
